//--- include/ltd_pkg.sv
package ltd_pkg;
  // ****************************************
  // modes on {mode_select_hi_pin, mode_select_lo_pin}
  // ****************************************
  localparam logic [1:0] LTD_MODE_NORMAL = 2'h0;
  localparam logic [1:0] LTD_MODE_FAST = 2'h1;
  localparam logic [1:0] LTD_MODE_DETECT = 2'h2;
  localparam logic [1:0] LTD_MODE_IDLE = 2'h3;
  // ****************************************
  // detect_config_reg layout
  // ****************************************
  localparam int LTD_CFG_W = 8;
  localparam int LTD_DUR_LSB = 0;
  localparam int LTD_DUR_W = 4;
  localparam int LTD_LVL_LSB = 4;
  localparam int LTD_LVL_W = 4;
  localparam logic [7:0] LTD_CFG_RESET = 8'h00;
  localparam logic [3:0] LTD_DUR_MAX = 4'hA;
  // ****************************************
  // timing
  // ****************************************
  localparam int LTD_CLK_HZ = 125000000;
  localparam int LTD_WINDOW_DIV_HZ = 50;
  localparam int LTD_WINDOW_ADD = 4;
  localparam int LTD_TICK_CYC = LTD_CLK_HZ / LTD_WINDOW_DIV_HZ;
  localparam int LTD_IDLE_S = 60;
  // host register offsets
  localparam logic [3:0] LTD_HOST_CTRL = 4'h0;
  localparam logic [3:0] LTD_HOST_CFG = 4'h1;
  localparam logic [3:0] LTD_HOST_STAT = 4'h2;
  typedef enum logic [4:0] {
    LTD_H_IDLE = 5'h01,
    LTD_H_DETECT = 5'h02,
    LTD_H_REST = 5'h04,
    LTD_H_FAST = 5'h08,
    LTD_H_NORMAL = 5'h10
  } ltd_host_state_t;
endpackage

//--- include/ltd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ltd_if;
  logic mode_select_lo_pin;
  logic mode_select_hi_pin;
  logic no_tamper_irq_n;
  logic tamper_found_irq_n;
  logic cfg_we;
  logic [7:0] cfg_data;
  modport dev (input mode_select_lo_pin, input mode_select_hi_pin, input cfg_we, input cfg_data,
               output no_tamper_irq_n, output tamper_found_irq_n);
  modport host (output mode_select_lo_pin, output mode_select_hi_pin, output cfg_we, output cfg_data,
                input no_tamper_irq_n, input tamper_found_irq_n);
endinterface
`default_nettype wire

//--- verilog/ltd_device.sv
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ltd_device import ltd_pkg::*; #(
  parameter int TICK_CYC = LTD_TICK_CYC
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  ltd_if.dev link,
  input wire logic [2:0] phase_above_i,
  input wire logic [15:0] phase_level_i [3],
  output logic [15:0] threshold_o,
  output logic comparator_on_o,
  output logic measure_on_o,
  output logic fast_measure_o,
  output logic [1:0] mode_o
);
  // ****************************************
  // mode decode and threshold table
  // ****************************************
  typedef enum logic [3:0] {
    LTD_W_OFF = 4'h1,
    LTD_W_COUNT = 4'h2,
    LTD_W_CLEAR = 4'h4,
    LTD_W_TAMPER = 4'h8
  } ltd_win_state_t;
  ltd_win_state_t win_state_reg;
  ltd_win_state_t win_state_next;
  logic [7:0] cfg_reg;
  logic [1:0] mode_prev_reg;
  logic [31:0] tick_cnt_reg;
  logic [4:0] win_cnt_reg;
  logic [4:0] peak_cnt_reg [3];
  logic [2:0] above_prev_reg;

  function automatic logic reached(input logic [4:0] cnt, input logic [4:0] lim);
    return cnt >= lim;
  endfunction

  // ratio numerators, rising with the code
  function automatic logic [15:0] ratio(input logic [3:0] code);
    logic [15:0] val;
    val = 16'h0000;
    unique case (code)
      4'h0: val = 16'h0090;
      4'h1: val = 16'h010F;
      4'h2: val = 16'h0179;
      4'h3: val = 16'h01F2;
      4'h4: val = 16'h0242;
      4'h5: val = 16'h0294;
      4'h6: val = 16'h02FC;
      4'h7: val = 16'h034D;
      4'h8: val = 16'h03CA;
      4'h9: val = 16'h044C;
      4'hA: val = 16'h04AC;
      4'hB: val = 16'h0520;
      4'hC: val = 16'h055B;
      4'hD: val = 16'h05B8;
      4'hE: val = 16'h0617;
      4'hF: val = 16'h065D;
    endcase
    return val;
  endfunction

  wire logic [1:0] mode = {link.mode_select_hi_pin, link.mode_select_lo_pin};
  wire logic in_normal = (mode == LTD_MODE_NORMAL);
  wire logic in_fast = (mode == LTD_MODE_FAST);
  wire logic in_detect = (mode == LTD_MODE_DETECT);
  wire logic entering = in_detect && (mode_prev_reg != LTD_MODE_DETECT);
  wire logic restart = !in_detect || entering;
  wire logic counting = !restart && (win_state_reg == LTD_W_COUNT);
  wire logic [3:0] dur = cfg_reg[LTD_DUR_LSB +: LTD_DUR_W];
  wire logic [3:0] lvl = cfg_reg[LTD_LVL_LSB +: LTD_LVL_W];
  wire logic tick = counting && (tick_cnt_reg == 32'(TICK_CYC - 1));
  wire logic [4:0] win_len = 5'(dur) + 5'(LTD_WINDOW_ADD);
  wire logic [4:0] need = 5'(dur) + 5'h01;
  wire logic [2:0] rise = phase_above_i & ~above_prev_reg;
  wire logic win_end = tick && (win_cnt_reg == win_len - 5'h01);
  wire logic any_hit = reached(peak_cnt_reg[0], need) || reached(peak_cnt_reg[1], need) ||
                       reached(peak_cnt_reg[2], need);
  // results show only while the mode pins still select detection
  wire logic show_clear = in_detect && (win_state_reg == LTD_W_CLEAR);
  wire logic show_tamper = in_detect && (win_state_reg == LTD_W_TAMPER);

  assign threshold_o = ratio(lvl);
  assign comparator_on_o = in_detect;
  assign measure_on_o = in_normal || in_fast;
  assign fast_measure_o = in_fast;
  assign mode_o = mode;
  // ****************************************
  // configuration, only in normal and fast modes
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_reg <= LTD_CFG_RESET;
    end else if (link.cfg_we && measure_on_o) begin
      cfg_reg <= link.cfg_data;
    end
  end
  // ****************************************
  // window state
  // ****************************************
  // a glitch on the mode pins restarts the window; the host must hold them steady
  always_comb begin
    win_state_next = win_state_reg;
    unique case (win_state_reg)
      LTD_W_OFF: begin
        if (in_detect) begin
          win_state_next = LTD_W_COUNT;
        end
      end
      LTD_W_COUNT: begin
        if (restart) begin
          win_state_next = in_detect ? LTD_W_COUNT : LTD_W_OFF;
        end else if (win_end) begin
          win_state_next = any_hit ? LTD_W_TAMPER : LTD_W_CLEAR;
        end
      end
      LTD_W_CLEAR, LTD_W_TAMPER: begin
        if (restart) begin
          win_state_next = in_detect ? LTD_W_COUNT : LTD_W_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      win_state_reg <= LTD_W_OFF;
    end else begin
      win_state_reg <= win_state_next;
    end
  end

  // ****************************************
  // mode history and comparator edges
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_prev_reg <= LTD_MODE_NORMAL;
      above_prev_reg <= 3'h0;
    end else begin
      mode_prev_reg <= mode;
      above_prev_reg <= in_detect ? phase_above_i : 3'h0;
    end
  end

  // ****************************************
  // window timing, counters idle outside the window
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt_reg <= '0;
    end else if (!counting) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      win_cnt_reg <= '0;
    end else if (!counting) begin
      win_cnt_reg <= '0;
    end else if (tick) begin
      win_cnt_reg <= win_cnt_reg + 5'h01;
    end
  end

  // ****************************************
  // per-phase peak counters, saturating
  // ****************************************
  for (genvar i = 0; i < 3; i++) begin : g_peak
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        peak_cnt_reg[i] <= '0;
      end else if (restart) begin
        peak_cnt_reg[i] <= '0;
      end else if (counting && rise[i] && peak_cnt_reg[i] != 5'h1F) begin
        peak_cnt_reg[i] <= peak_cnt_reg[i] + 5'h01;
      end
    end
  end

  // ****************************************
  // result pins, held high until window end
  // ****************************************
  assign link.no_tamper_irq_n = !show_clear;
  assign link.tamper_found_irq_n = !show_tamper;
endmodule // ltd_device
`default_nettype wire

//--- verilog/ltd_host.sv
`timescale 1ns/1ps
`default_nettype none
module ltd_host import ltd_pkg::*; #(
  parameter int DETECT_WAIT_CYC = 15 * LTD_TICK_CYC,
  parameter longint IDLE_CYC = longint'(LTD_IDLE_S) * LTD_CLK_HZ,
  parameter int FAST_CYC = LTD_CLK_HZ
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  ltd_if.host link,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o
);
  // ****************************************
  // registers: ctrl bit0 = run, cfg, status
  // ****************************************
  ltd_host_state_t state_reg;
  logic run_reg;
  logic [7:0] cfg_reg;
  // one minute of idle at full clock rate needs 33 bits
  logic [32:0] wait_reg;
  logic seen_tamper_reg;
  logic seen_clear_reg;
  logic [1:0] pins_reg;
  logic cfg_we_reg;
  logic [31:0] rdata_reg;
  // field above ten is clamped before it reaches the device
  wire logic [3:0] dur_in = wdata_i[LTD_DUR_LSB +: LTD_DUR_W];
  wire logic [3:0] dur_ok = (dur_in > LTD_DUR_MAX) ? LTD_DUR_MAX : dur_in;
  // refused once run is set, so a late write cannot land after the pins move to detection
  wire logic can_cfg = ((state_reg == LTD_H_IDLE) || (state_reg == LTD_H_NORMAL)) && !run_reg;
  wire logic waited = (wait_reg == 33'h0);
  wire logic [31:0] stat = {27'h0, seen_clear_reg, seen_tamper_reg,
                            !link.tamper_found_irq_n, !link.no_tamper_irq_n, run_reg};

  assign link.mode_select_hi_pin = pins_reg[1];
  assign link.mode_select_lo_pin = pins_reg[0];
  assign link.cfg_we = cfg_we_reg;
  assign link.cfg_data = cfg_reg;
  assign rdata_o = rdata_reg;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_reg <= LTD_CFG_RESET;
      cfg_we_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      cfg_we_reg <= wr_i && addr_i == LTD_HOST_CFG && can_cfg;
      if (wr_i && addr_i == LTD_HOST_CFG && can_cfg) begin
        cfg_reg <= {wdata_i[LTD_LVL_LSB +: LTD_LVL_W], dur_ok};
      end
      unique case (addr_i)
        LTD_HOST_CTRL: rdata_reg <= rd_i ? {31'h0, run_reg} : '0;
        LTD_HOST_CFG: rdata_reg <= rd_i ? {24'h0, cfg_reg} : '0;
        LTD_HOST_STAT: rdata_reg <= rd_i ? stat : '0;
        default: rdata_reg <= '0;
      endcase
    end
  end
  // ****************************************
  // mode sequencer
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= LTD_H_IDLE;
      pins_reg <= LTD_MODE_NORMAL;
      run_reg <= 1'b0;
      wait_reg <= '0;
      seen_tamper_reg <= 1'b0;
      seen_clear_reg <= 1'b0;
    end else begin
      if (wr_i && addr_i == LTD_HOST_CTRL) begin
        run_reg <= wdata_i[0];
      end
      if (wr_i && addr_i == LTD_HOST_STAT) begin
        seen_tamper_reg <= seen_tamper_reg & ~wdata_i[3];
        seen_clear_reg <= seen_clear_reg & ~wdata_i[4];
      end
      if (!waited) begin
        wait_reg <= wait_reg - 33'h1;
      end
      unique case (state_reg)
        LTD_H_IDLE, LTD_H_NORMAL: begin
          pins_reg <= LTD_MODE_NORMAL;
          if (run_reg && !cfg_we_reg) begin
            state_reg <= LTD_H_DETECT;
            pins_reg <= LTD_MODE_DETECT;
            wait_reg <= 33'(DETECT_WAIT_CYC);
          end
        end
        LTD_H_DETECT: begin
          // sample pins only after the full window has passed
          if (waited && !link.tamper_found_irq_n) begin
            state_reg <= LTD_H_FAST;
            pins_reg <= LTD_MODE_FAST;
            seen_tamper_reg <= 1'b1;
            wait_reg <= 33'(FAST_CYC);
          end else if (waited && !link.no_tamper_irq_n) begin
            state_reg <= LTD_H_REST;
            pins_reg <= LTD_MODE_IDLE;
            seen_clear_reg <= 1'b1;
            wait_reg <= 33'(IDLE_CYC);
          end
        end
        LTD_H_REST: begin
          if (waited) begin
            state_reg <= run_reg ? LTD_H_DETECT : LTD_H_NORMAL;
            pins_reg <= run_reg ? LTD_MODE_DETECT : LTD_MODE_NORMAL;
            wait_reg <= 33'(DETECT_WAIT_CYC);
          end
        end
        LTD_H_FAST: begin
          if (waited) begin
            state_reg <= LTD_H_NORMAL;
            pins_reg <= LTD_MODE_NORMAL;
          end
        end
      endcase
    end
  end
endmodule // ltd_host
`default_nettype wire

//--- verification/ltd_props.sv
`timescale 1ns/1ps
`default_nettype none
module ltd_props import ltd_pkg::*; #(
  parameter int TICK_CYC = LTD_TICK_CYC
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic mode_select_lo_pin,
  input wire logic mode_select_hi_pin,
  input wire logic no_tamper_irq_n,
  input wire logic tamper_found_irq_n,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_data
);
  logic [1:0] md;
  logic [3:0] dur_reg;
  int cnt_reg;
  int win;
  assign md = {mode_select_hi_pin, mode_select_lo_pin};
  assign win = (int'(dur_reg) + LTD_WINDOW_ADD) * TICK_CYC;
  // mirrors the device: config only lands outside detect and idle
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dur_reg <= LTD_CFG_RESET[3:0];
      cnt_reg <= 0;
    end else begin
      if (cfg_we && !md[1]) dur_reg <= cfg_data[3:0];
      cnt_reg <= (md == LTD_MODE_DETECT) ? cnt_reg + 1 : 0;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  chk_irq_excl: assert property (no_tamper_irq_n || tamper_found_irq_n)
    else $error("both result pins low");
  chk_irq_mode: assert property (!(no_tamper_irq_n && tamper_found_irq_n) |-> md == LTD_MODE_DETECT)
    else $error("result pin low outside detect");
  chk_irq_hold: assert property ($past(md) == LTD_MODE_DETECT && md == LTD_MODE_DETECT |->
    no_tamper_irq_n <= $past(no_tamper_irq_n) && tamper_found_irq_n <= $past(tamper_found_irq_n))
    else $error("result pin released in detect");
  chk_win_quiet: assert property (md == LTD_MODE_DETECT && cnt_reg < win |-> no_tamper_irq_n && tamper_found_irq_n)
    else $error("result before window end");
  chk_win_len: assert property ($fell(no_tamper_irq_n) || $fell(tamper_found_irq_n) |->
    cnt_reg >= win && cnt_reg <= win + 3)
    else $error("window length wrong");
  chk_cfg_mode: assert property (cfg_we |-> !md[1])
    else $error("config written in detect or idle");
  chk_cfg_dur: assert property (cfg_we |-> cfg_data[3:0] <= LTD_DUR_MAX)
    else $error("duration above limit");
  chk_fast_next: assert property ($past(md) == LTD_MODE_DETECT && md != LTD_MODE_DETECT
    && !$past(tamper_found_irq_n) |-> md == LTD_MODE_FAST)
    else $error("no fast mode after tamper");
  chk_idle_next: assert property ($past(md) == LTD_MODE_DETECT && md != LTD_MODE_DETECT
    && !$past(no_tamper_irq_n) |-> md == LTD_MODE_IDLE)
    else $error("no idle after clear result");
  chk_leave_late: assert property ($past(md) == LTD_MODE_DETECT && md != LTD_MODE_DETECT |->
    !$past(no_tamper_irq_n) || !$past(tamper_found_irq_n))
    else $error("detect left before result");
endmodule // ltd_props
`default_nettype wire

//--- verification/low_power_tamper_detector_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module low_power_tamper_detector_tb import ltd_pkg::*; ;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] above = 3'h0;
  logic [15:0] level [3];
  logic [31:0] rdata;
  logic [15:0] thr;
  logic cmp_on, meas_on, fast_on;
  logic [1:0] mode_seen;
  int failures = 0;
  int checks_done = 0;
  logic [15:0] tbl [16] = '{16'h0090, 16'h010F, 16'h0179, 16'h01F2, 16'h0242, 16'h0294, 16'h02FC, 16'h034D,
    16'h03CA, 16'h044C, 16'h04AC, 16'h0520, 16'h055B, 16'h05B8, 16'h0617, 16'h065D};
  ltd_if link ();
  wire [1:0] pins = {link.mode_select_hi_pin, link.mode_select_lo_pin};
  always #4 ref_clk_i = ~ref_clk_i;
  ltd_device #(.TICK_CYC(10)) i_ltd_device (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link),
    .phase_above_i(above), .phase_level_i(level), .threshold_o(thr), .comparator_on_o(cmp_on),
    .measure_on_o(meas_on), .fast_measure_o(fast_on), .mode_o(mode_seen));
  ltd_host #(.DETECT_WAIT_CYC(150), .IDLE_CYC(20), .FAST_CYC(20)) i_ltd_host (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .link(link), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
  ltd_props #(.TICK_CYC(10)) i_ltd_props (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .mode_select_lo_pin(link.mode_select_lo_pin), .mode_select_hi_pin(link.mode_select_hi_pin),
    .no_tamper_irq_n(link.no_tamper_irq_n), .tamper_found_irq_n(link.tamper_found_irq_n),
    .cfg_we(link.cfg_we), .cfg_data(link.cfg_data));
  task report_and_stop();
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // bounded wait for a pin mode, or for either result pin low
  task wait_for(input logic [1:0] m, input bit irq);
    int n;
    for (n = 0; n < 400; n++) begin
      if (irq ? (link.no_tamper_irq_n & link.tamper_found_irq_n) === 1'b0 : pins === m) break;
      @(posedge ref_clk_i);
      #1;
    end
    if (n == 400) begin
      failures++;
      report_and_stop();
    end
  endtask
  // one detect pass: k peaks on one phase, then the result and the next mode
  task pass(input int ch, input int k, input bit tamper);
    wait_for(LTD_MODE_DETECT, 1'b0);
    `CHK("comparator_on", 1'b1, cmp_on)
    `CHK("measure_on", 1'b0, meas_on)
    `CHK("mode_o", LTD_MODE_DETECT, mode_seen)
    repeat (k) begin
      @(posedge ref_clk_i);
      above[ch] <= 1'b1;
      @(posedge ref_clk_i);
      above[ch] <= 1'b0;
    end
    #1;
    `CHK("early result", 2'h3, {link.no_tamper_irq_n, link.tamper_found_irq_n})
    wait_for(LTD_MODE_NORMAL, 1'b1);
    `CHK("no_tamper_irq_n", tamper, link.no_tamper_irq_n)
    `CHK("tamper_found_irq_n", !tamper, link.tamper_found_irq_n)
    wait_for(tamper ? LTD_MODE_FAST : LTD_MODE_IDLE, 1'b0);
  endtask
  initial begin
    int i;
    logic [31:0] st;
    level = '{default: 16'h0000};
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    #1;
    `CHK("reset pins", LTD_MODE_NORMAL, pins)
    `CHK("normal measure", 1'b1, meas_on)
    for (i = 0; i < 16; i++) begin
      wr_reg(LTD_HOST_CFG, {24'h0, 4'(i), 4'h2});
      repeat (3) @(posedge ref_clk_i);
      #1;
      `CHK("threshold", tbl[i], thr)
    end
    wr_reg(LTD_HOST_CFG, 32'h0000000B);
    rd_reg(LTD_HOST_CFG, st);
    `CHK("duration clamp", 8'h0A, st[7:0])
    wr_reg(LTD_HOST_CFG, 32'h00000002);
    wr_reg(LTD_HOST_CTRL, 32'h00000001);
    // second clear pass proves the counters restart on entry
    pass(0, 2, 1'b0);
    pass(0, 2, 1'b0);
    pass(2, 3, 1'b1);
    `CHK("fast measure", 1'b1, fast_on)
    wr_reg(LTD_HOST_CTRL, 32'h00000000);
    wait_for(LTD_MODE_NORMAL, 1'b0);
    rd_reg(LTD_HOST_STAT, st);
    `CHK("seen flags", 2'h3, st[4:3])
    report_and_stop();
  end
endmodule // low_power_tamper_detector_tb
`default_nettype wire
